// >>> sew_top.sv
// Function
// - A set write-enable latch is required before any array or configuration write.
// - Latch-set followed by more clocks in one select period is discarded.
// - Array write is command, 16-bit address, then data bytes, select low.
// - Array write needs at least 32 clocks with select held low.
// - Page address counter wraps inside the page, overwriting earlier bytes.
// - Nonvolatile write starts only when select rises after a whole data byte.
// - Idle status read returns watchdog and protection bits, others zero.
// - During a nonvolatile write status reads return one in the top bit.
// - First status read after completion shows zero top bit, then true contents.
// - Reset output low on supply-low or watchdog timeout.
// - After power-up a command is taken only after a select falling edge.
// - Power-up clears latch, floats serial output, holds reset for hold time.
// - Serial commands are ignored while supply-low is present.
// - Command codes fixed for latch set/clear, config write/read, array write/read.
// - Low three config bits select protected range; watchdog bits above them.
// - Watchdog codes select long, mid, short period or disabled by default.
`timescale 1ns/1ns
module sew_top #(
  parameter int unsigned WC_CYCLES   = sew_pkg::WRITE_CYCLE_CYC,
  parameter int unsigned PU_CYCLES   = sew_pkg::POWERUP_HOLD_CYC,
  parameter int unsigned RST_CYCLES  = sew_pkg::RESET_HOLD_CYC,
  parameter int unsigned WD0_CYCLES  = sew_pkg::WDOG_LONG_CYC,
  parameter int unsigned WD1_CYCLES  = sew_pkg::WDOG_MID_CYC,
  parameter int unsigned WD2_CYCLES  = sew_pkg::WDOG_SHORT_CYC,
  parameter int unsigned FIFO_DEPTH  = 8
) (
  input  wire logic sys_clk_i,
  input  wire logic resetn_i,
  input  wire logic cs_n_i,
  input  wire logic sck_i,
  input  wire logic si_i,
  input  wire logic vcc_low_i,
  output logic      so_o,
  output logic      so_oe_o,
  output logic      rst_n_o,
  output logic      rst_n_oe_o,
  output logic      busy_o
);
  localparam int unsigned FW = $bits(sew_pkg::sew_wr_t);

  generate
    if (WC_CYCLES < 1 || PU_CYCLES < 1 || RST_CYCLES < 1) begin : g_bad_time
      $error("sew_top timing counts must be at least one cycle");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection
  logic [1:0] cs_sync_q;
  logic [1:0] sck_sync_q;
  logic [1:0] si_sync_q;
  logic [1:0] vl_sync_q;
  logic       cs_dly_q;
  logic       sck_dly_q;
  logic       cs_s;
  logic       sck_s;
  logic       si_s;
  logic       vcc_low_s;

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      cs_sync_q  <= 2'h3;
      sck_sync_q <= 2'h0;
      si_sync_q  <= 2'h0;
      vl_sync_q  <= 2'h0;
      cs_dly_q   <= 1'b1;
      sck_dly_q  <= 1'b0;
    end else begin
      cs_sync_q  <= {cs_sync_q[0], cs_n_i};
      sck_sync_q <= {sck_sync_q[0], sck_i};
      si_sync_q  <= {si_sync_q[0], si_i};
      vl_sync_q  <= {vl_sync_q[0], vcc_low_i};
      cs_dly_q   <= cs_sync_q[1];
      sck_dly_q  <= sck_sync_q[1];
    end
  end

  assign cs_s      = cs_sync_q[1];
  assign sck_s     = sck_sync_q[1];
  assign si_s      = si_sync_q[1];
  assign vcc_low_s = vl_sync_q[1];

  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  assign cs_fall  = cs_dly_q & ~cs_s;
  assign cs_rise  = ~cs_dly_q & cs_s;
  assign sck_rise = sck_s & ~sck_dly_q;
  assign sck_fall = ~sck_s & sck_dly_q;

  ////////////////////////////////////////////////////////////////////////////
  // Select period tracking
  logic       armed_q;
  logic       active;
  logic [2:0] phase_q;
  logic [2:0] nbytes_q;
  logic [6:0] shin_q;
  logic [7:0] cmd_q;
  logic [7:0] byte_in;
  logic       byte_done;
  logic       busy;

  // armed only by select fall; inhibited on supply low
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      armed_q <= 1'b0;
    end else if (vcc_low_s || cs_rise) begin
      armed_q <= 1'b0;
    end else if (cs_fall) begin
      armed_q <= 1'b1;
    end
  end

  assign active    = armed_q & ~cs_s & ~vcc_low_s;
  assign byte_done = active & sck_rise & (phase_q == 3'h7);
  assign byte_in   = {shin_q, si_s};

  // command, address, data bytes counted per select
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i || cs_fall) begin
      phase_q  <= 3'h0;
      nbytes_q <= 3'h0;
      shin_q   <= 7'h00;
      cmd_q    <= 8'h00;
    end else if (active && sck_rise) begin
      shin_q  <= byte_in[6:0];
      phase_q <= phase_q + 3'h1;
      if (phase_q == 3'h7) begin
        if (nbytes_q != 3'h4) begin
          nbytes_q <= nbytes_q + 3'h1;
        end
        if (nbytes_q == 3'h0) begin
          cmd_q <= byte_in;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address capture and page buffer
  logic [7:0]  addr_hi_q;
  logic [5:0]  page_q;
  logic [3:0]  off_q;
  logic [7:0]  pbuf_q [sew_pkg::PAGE_BYTES];
  logic [15:0] pvld_q;
  logic [7:0]  cfg_new_q;

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i || cs_fall) begin
      addr_hi_q <= 8'h00;
      page_q    <= 6'h00;
      off_q     <= 4'h0;
      pvld_q    <= 16'h0000;
      cfg_new_q <= 8'h00;
    end else if (byte_done) begin
      if (nbytes_q == 3'h1) begin
        addr_hi_q <= byte_in;
        cfg_new_q <= byte_in;
      end else if (nbytes_q == 3'h2) begin
        // bits above the array are taken as zero
        page_q <= {addr_hi_q[1:0], byte_in[7:4]};
        off_q  <= byte_in[3:0];
      end else if (cmd_q == sew_pkg::CMD_ARR_WRITE) begin
        // offset wraps within the sixteen-byte page
        pvld_q[off_q] <= 1'b1;
        off_q         <= off_q + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (byte_done && nbytes_q >= 3'h3 && cmd_q == sew_pkg::CMD_ARR_WRITE) begin
      pbuf_q[off_q] <= byte_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latch and commit decisions at select rise
  logic wel_q;
  logic whole;
  logic arr_go;
  logic cfg_go;

  // only a rise after whole bytes, and enough of them, commits
  assign whole  = armed_q & cs_rise & (phase_q == 3'h0);
  assign arr_go = whole & wel_q & ~busy & (nbytes_q == 3'h4) & (cmd_q == sew_pkg::CMD_ARR_WRITE);
  // configuration write is exactly command and one byte
  assign cfg_go = whole & wel_q & ~busy & (nbytes_q == 3'h2) & (cmd_q == sew_pkg::CMD_CFG_WRITE);

  logic cycle_end;

  // latch set/clear commands act only for an exact eight-bit select; a committed write also clears it; clear at power-up
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      wel_q <= 1'b0;
    end else if (whole && nbytes_q == 3'h1 && !busy && cmd_q == sew_pkg::CMD_LATCH_SET) begin
      wel_q <= 1'b1;
    end else if (arr_go || cfg_go) begin
      wel_q <= 1'b0;
    end else if (whole && nbytes_q == 3'h1 && cmd_q == sew_pkg::CMD_LATCH_CLEAR) begin
      wel_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Nonvolatile write engine
  logic [7:0]  cfg_q;
  logic [7:0]  cfg_pend_q;
  logic        cfg_pend_q_v;
  logic [31:0] wc_cnt_q;
  logic        seq_on_q;
  logic [3:0]  seq_idx_q;
  logic [5:0]  seq_page_q;
  logic [7:0]  seq_buf_q [sew_pkg::PAGE_BYTES];
  logic [15:0] seq_vld_q;
  logic        done_unread_q;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic        fifo_in_valid;
  logic        drain_en;
  logic [1:0]  div_q;
  sew_pkg::sew_wr_t fifo_in;
  sew_pkg::sew_wr_t fifo_out;
  logic [9:0]  seq_addr;

  // protected range check against the current region select
  function automatic logic is_protected(input logic [9:0] a, input logic [2:0] sel);
    logic hit;
    hit = 1'b0;
    unique case (sel)
      sew_pkg::PROT_NONE:  hit = 1'b0;
      sew_pkg::PROT_HALF:  hit = (a[9] == 1'b0);
      sew_pkg::PROT_PAGE0: hit = (a[9:4] == 6'h00);
      sew_pkg::PROT_PAGEN: hit = (a[9:4] == 6'h3F);
      default:             hit = (a[9:8] == 2'(sel - 3'h1));
    endcase
    return hit;
  endfunction

  assign seq_addr      = {seq_page_q, seq_idx_q};
  assign fifo_in.addr  = seq_addr;
  assign fifo_in.data  = seq_buf_q[seq_idx_q];
  assign fifo_in_valid = seq_on_q & seq_vld_q[seq_idx_q] &
                         ~is_protected(seq_addr, cfg_q[sew_pkg::PROT_LSB +: sew_pkg::PROT_W]);
  assign busy          = seq_on_q | fifo_out_valid | (wc_cnt_q != 32'h0) | cfg_pend_q_v;
  assign cycle_end     = busy & ~seq_on_q & ~fifo_out_valid & (wc_cnt_q <= 32'h1);
  assign drain_en      = (div_q == 2'h0);

  always_ff @(posedge sys_clk_i) begin
    if (arr_go) begin
      seq_buf_q <= pbuf_q;
    end
  end

  // Page buffer walked into the FIFO; stalls while the FIFO is full
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      seq_on_q   <= 1'b0;
      seq_idx_q  <= 4'h0;
      seq_page_q <= 6'h00;
      seq_vld_q  <= 16'h0000;
    end else if (arr_go) begin
      seq_on_q   <= 1'b1;
      seq_idx_q  <= 4'h0;
      seq_page_q <= page_q;
      seq_vld_q  <= pvld_q;
    end else if (seq_on_q && (!fifo_in_valid || fifo_in_ready)) begin
      seq_idx_q <= seq_idx_q + 4'h1;
      if (seq_idx_q == 4'hF) begin
        seq_on_q <= 1'b0;
      end
    end
  end

  // Array port is slower than the FIFO fill so back-pressure really occurs
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      div_q <= 2'h0;
    end else begin
      div_q <= (div_q == 2'(sew_pkg::DRAIN_DIV - 1)) ? 2'h0 : div_q + 2'h1;
    end
  end

  sew_fifo #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .resetn_i    (resetn_i),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (fifo_in),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (drain_en),
    .out_data_o  (fifo_out)
  );

  logic [7:0] array_q [1024];

  always_ff @(posedge sys_clk_i) begin
    if (fifo_out_valid && drain_en) begin
      array_q[fifo_out.addr] <= fifo_out.data;
    end
  end

  // Self-timed write cycle; it never ends before the FIFO is drained
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      wc_cnt_q     <= 32'h0;
      cfg_q        <= sew_pkg::CFG_RESET;
      cfg_pend_q   <= 8'h00;
      cfg_pend_q_v <= 1'b0;
    end else begin
      if (arr_go || cfg_go) begin
        wc_cnt_q <= WC_CYCLES;
      end else if (wc_cnt_q > 32'h1 || (wc_cnt_q == 32'h1 && !seq_on_q && !fifo_out_valid)) begin
        // Last count held until drained, so the done flag is never missed
        wc_cnt_q <= wc_cnt_q - 32'h1;
      end
      if (cfg_go) begin
        cfg_pend_q   <= cfg_new_q & sew_pkg::CFG_USED;
        cfg_pend_q_v <= 1'b1;
      end else if (cycle_end && cfg_pend_q_v) begin
        cfg_q        <= cfg_pend_q;
        cfg_pend_q_v <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial output
  logic [7:0] shout_q;
  logic [9:0] rd_addr_q;
  logic [7:0] stat_view;
  logic       so_q;
  logic       so_oe_q;
  logic       stat_load;

  // status byte seen by the host
  assign stat_view = busy          ? sew_pkg::STAT_BUSY :
                     done_unread_q ? sew_pkg::STAT_DONE :
                                     (cfg_q & sew_pkg::CFG_USED);
  assign stat_load = byte_done & ((nbytes_q == 3'h0) ? (byte_in == sew_pkg::CMD_CFG_READ) :
                                                       (cmd_q == sew_pkg::CMD_CFG_READ));

  // set wins over the clear in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      done_unread_q <= 1'b0;
    end else if (cycle_end) begin
      done_unread_q <= 1'b1;
    end else if (stat_load && !busy) begin
      done_unread_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i || cs_fall) begin
      shout_q   <= 8'h00;
      rd_addr_q <= 10'h000;
    end else if (stat_load) begin
      shout_q <= stat_view;
    end else if (byte_done && nbytes_q >= 3'h2 && cmd_q == sew_pkg::CMD_ARR_READ) begin
      shout_q   <= array_q[(nbytes_q == 3'h2) ? {addr_hi_q[1:0], byte_in} : rd_addr_q];
      rd_addr_q <= ((nbytes_q == 3'h2) ? {addr_hi_q[1:0], byte_in} : rd_addr_q) + 10'h001;
    end else if (active && sck_fall) begin
      shout_q <= {shout_q[6:0], 1'b0};
    end
  end

  // output floats from reset until a status read command or an array read address is decoded
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i || !active) begin
      so_q    <= 1'b0;
      so_oe_q <= 1'b0;
    end else if (sck_fall && nbytes_q != 3'h0 &&
                 (cmd_q == sew_pkg::CMD_CFG_READ || (cmd_q == sew_pkg::CMD_ARR_READ && nbytes_q >= 3'h3))) begin
      so_q    <= shout_q[7];
      so_oe_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Supervisor: power-up hold, supply low, watchdog
  logic [31:0] hold_q;
  logic [31:0] wd_q;
  logic [31:0] wd_limit;
  logic        wd_expire;
  logic        rst_drv_q;
  logic        busy_q;

  // period chosen from the watchdog field
  always_comb begin
    wd_limit = 32'h0;
    unique case (cfg_q[sew_pkg::WDOG_LSB +: sew_pkg::WDOG_W])
      sew_pkg::WDOG_LONG:  wd_limit = WD0_CYCLES;
      sew_pkg::WDOG_MID:   wd_limit = WD1_CYCLES;
      sew_pkg::WDOG_SHORT: wd_limit = WD2_CYCLES;
      sew_pkg::WDOG_OFF:   wd_limit = 32'h0;
    endcase
  end

  assign wd_expire = (wd_limit != 32'h0) & (wd_q >= wd_limit - 32'h1) & (hold_q == 32'h0);

  // hold reset after power-up, supply low or watchdog timeout
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      hold_q <= PU_CYCLES;
    end else if (vcc_low_s) begin
      hold_q <= RST_CYCLES;
    end else if (wd_expire) begin
      hold_q <= RST_CYCLES;
    end else if (hold_q != 32'h0) begin
      hold_q <= hold_q - 32'h1;
    end
  end

  // Select falling edge restarts the watchdog
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i || cs_fall || hold_q != 32'h0 || wd_limit == 32'h0) begin
      wd_q <= 32'h0;
    end else begin
      wd_q <= wd_q + 32'h1;
    end
  end

  // open-drain pin pulled low while any cause holds
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      rst_drv_q <= 1'b1;
      busy_q    <= 1'b0;
    end else begin
      rst_drv_q <= vcc_low_s | wd_expire | (hold_q != 32'h0);
      busy_q    <= busy;
    end
  end

  assign so_o       = so_q;
  assign so_oe_o    = so_oe_q;
  assign rst_n_o    = 1'b0;
  assign rst_n_oe_o = rst_drv_q;
  assign busy_o     = busy_q;
endmodule

// >>> sew_pkg.sv
package sew_pkg;

  // Command codes
  localparam logic [7:0] CMD_LATCH_SET   = 8'h06;
  localparam logic [7:0] CMD_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] CMD_CFG_WRITE   = 8'h01;
  localparam logic [7:0] CMD_CFG_READ    = 8'h05;
  localparam logic [7:0] CMD_ARR_WRITE   = 8'h02;
  localparam logic [7:0] CMD_ARR_READ    = 8'h03;

  // Array geometry
  localparam int unsigned ADDR_W      = 10;
  localparam int unsigned PAGE_W      = 4;
  localparam int unsigned PAGE_BYTES  = 16;
  localparam logic [9:0]  ADDR_TOP    = 10'h3FF;

  // Status/configuration byte layout
  localparam int unsigned PROT_LSB    = 0;
  localparam int unsigned PROT_W      = 3;
  localparam int unsigned WDOG_LSB    = 3;
  localparam int unsigned WDOG_W      = 2;
  localparam logic [7:0]  CFG_RESET   = 8'h18;
  localparam logic [7:0]  CFG_USED    = 8'h1F;
  localparam logic [7:0]  STAT_BUSY   = 8'h80;
  localparam logic [7:0]  STAT_DONE   = 8'h00;

  // Protection region codes
  localparam logic [2:0] PROT_NONE  = 3'h0;
  localparam logic [2:0] PROT_HALF  = 3'h5;
  localparam logic [2:0] PROT_PAGE0 = 3'h6;
  localparam logic [2:0] PROT_PAGEN = 3'h7;

  // Watchdog period codes
  localparam logic [1:0] WDOG_LONG  = 2'h0;
  localparam logic [1:0] WDOG_MID   = 2'h1;
  localparam logic [1:0] WDOG_SHORT = 2'h2;
  localparam logic [1:0] WDOG_OFF   = 2'h3;

  // Timing, printed units, converted at the system clock rate
  localparam int unsigned SYS_CLK_KHZ      = 250000;
  localparam int unsigned WRITE_CYCLE_MS   = 10;
  localparam int unsigned POWERUP_HOLD_MS  = 200;
  localparam int unsigned RESET_HOLD_MS    = 200;
  localparam int unsigned WDOG_LONG_MS     = 1400;
  localparam int unsigned WDOG_MID_MS      = 600;
  localparam int unsigned WDOG_SHORT_MS    = 200;
  localparam int unsigned WRITE_CYCLE_CYC  = WRITE_CYCLE_MS * SYS_CLK_KHZ;
  localparam int unsigned POWERUP_HOLD_CYC = POWERUP_HOLD_MS * SYS_CLK_KHZ;
  localparam int unsigned RESET_HOLD_CYC   = RESET_HOLD_MS * SYS_CLK_KHZ;
  localparam int unsigned WDOG_LONG_CYC    = WDOG_LONG_MS * SYS_CLK_KHZ;
  localparam int unsigned WDOG_MID_CYC     = WDOG_MID_MS * SYS_CLK_KHZ;
  localparam int unsigned WDOG_SHORT_CYC   = WDOG_SHORT_MS * SYS_CLK_KHZ;
  localparam int unsigned DRAIN_DIV        = 4;

  // One buffered array write
  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] data;
  } sew_wr_t;

endpackage

// >>> sew_fifo.sv
`timescale 1ns/1ns
module sew_fifo #(
  parameter int unsigned WIDTH = 18,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             sys_clk_i,
  input  wire logic             resetn_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int unsigned PW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("sew_fifo depth must be a power of two, at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW:0]      wr_q;
  logic [PW:0]      rd_q;
  logic             push;
  logic             pop;

  assign in_ready_o  = (wr_q - rd_q) != (PW+1)'(DEPTH);
  assign out_valid_o = wr_q != rd_q;
  assign out_data_o  = mem_q[rd_q[PW-1:0]];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_q[wr_q[PW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule

// >>> sew_checker.sv
`timescale 1ns/1ns
module sew_checker #(
  parameter int unsigned WC_CYCLES = 200
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic si_i,
  input wire logic vcc_low_i,
  input wire logic so_o,
  input wire logic so_oe_o,
  input wire logic rst_n_o,
  input wire logic rst_n_oe_o,
  input wire logic busy_o
);
  logic [31:0] busy_len_q;

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i || !busy_o) begin
      busy_len_q <= 32'h0;
    end else begin
      busy_len_q <= busy_len_q + 32'h1;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  ////////////////////////////////////////////////////////////////
  pu_hold_a: assert property ($rose(resetn_i) |-> rst_n_oe_o [*8])
    else $error("reset output not held after power-up");
  pin_low_a: assert property (rst_n_o == 1'b0)
    else $error("open-drain reset value not low");
  supply_reset_a: assert property (vcc_low_i [*3] |-> ##[0:3] rst_n_oe_o)
    else $error("supply low did not assert reset");
  quiet_low_a: assert property (vcc_low_i [*6] |-> !so_oe_o)
    else $error("serial out driven during supply low");
  so_float_a: assert property (cs_n_i [*6] |-> !so_oe_o)
    else $error("serial out driven while deselected");
  so_enable_a: assert property ($rose(so_oe_o) |-> !$past(cs_n_i, 8))
    else $error("serial out enabled outside a frame");
  so_shift_a: assert property (so_oe_o && $past(so_oe_o) && (so_o != $past(so_o)) |-> !$past(sck_i, 2))
    else $error("serial out changed while clock high");
  busy_start_a: assert property ($rose(busy_o) |-> $past(cs_n_i, 3))
    else $error("write cycle began while selected");
  busy_len_a: assert property ($fell(busy_o) |-> busy_len_q >= WC_CYCLES)
    else $error("write cycle too short");

  cover property ($fell(busy_o));
  cover property ($rose(so_oe_o));
  cover property (vcc_low_i && rst_n_oe_o);
endmodule

bind sew_top sew_checker #(.WC_CYCLES(WC_CYCLES)) u_chk (
  .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .cs_n_i(cs_n_i), .sck_i(sck_i), .si_i(si_i),
  .vcc_low_i(vcc_low_i), .so_o(so_o), .so_oe_o(so_oe_o), .rst_n_o(rst_n_o),
  .rst_n_oe_o(rst_n_oe_o), .busy_o(busy_o));

// >>> sew_host.sv
`timescale 1ns/1ns
module sew_host (
  input  wire logic sys_clk_i,
  input  wire logic so_i,
  input  wire logic so_oe_i,
  output logic      cs_n_o,
  output logic      sck_o,
  output logic      si_o
);
  logic [7:0] tx [0:23];
  logic [7:0] rx [0:23];
  logic       last_q;

  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
    last_q = 1'b0;
  end

  // select held low for whole frame, MSB first
  task automatic xfer(input int nbits);
    int i;
    @(posedge sys_clk_i) cs_n_o <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    for (i = 0; i < nbits; i++) begin
      si_o <= tx[i/8][7-i%8];
      repeat (4) @(posedge sys_clk_i);
      sck_o <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      // Floating line shows no stale value
      last_q = so_oe_i ? so_i : ~last_q;
      rx[i/8][7-i%8] = last_q;
      sck_o <= 1'b0;
    end
    repeat (4) @(posedge sys_clk_i);
    cs_n_o <= 1'b1;
    si_o <= ~si_o;
    repeat (30) @(posedge sys_clk_i);
  endtask
endmodule

// >>> spi_eeprom_write_status_ctrl_test.sv
`timescale 1ns/1ns
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fail_count++; \
  $display("unexpected at %0t: %0h vs %0h", $time, (a), (e)); end end
module spi_eeprom_write_status_ctrl_test;
  logic sys_clk_i;
  logic resetn_i;
  logic vcc_low_i;
  logic cs_n, sck, si, so, so_oe, rst_n, rst_oe, busy, seen;
  int   fail_count, checks_done, cyc, n, k;

  sew_top #(.WC_CYCLES(400), .PU_CYCLES(50), .RST_CYCLES(50), .WD2_CYCLES(500)) u_dut (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
    .vcc_low_i(vcc_low_i), .so_o(so), .so_oe_o(so_oe), .rst_n_o(rst_n), .rst_n_oe_o(rst_oe), .busy_o(busy));
  sew_host u_host (.sys_clk_i(sys_clk_i), .so_i(so), .so_oe_i(so_oe), .cs_n_o(cs_n), .sck_o(sck), .si_o(si));

  ////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic cmd(input logic [7:0] c, input int nbits);
    u_host.tx[0] = c;
    u_host.xfer(nbits);
  endtask
  // latch set alone in its frame
  task automatic latch();
    cmd(8'h06, 8);
  endtask
  task automatic hdr(input logic [7:0] c, input logic [9:0] a);
    u_host.tx[0] = c;
    u_host.tx[1] = {6'h00, a[9:8]};
    u_host.tx[2] = a[7:0];
  endtask
  task automatic settle();
    seen = 1'b0;
    for (n = 0; n < 800 && !(seen && busy === 1'b0); n++) begin
      @(negedge sys_clk_i);
      if (busy === 1'b1) seen = 1'b1;
    end
  endtask
  task automatic rd_stat(input logic [7:0] e);
    cmd(8'h05, 16);
    `CHK(u_host.rx[1], e)
  endtask
  task automatic wr1(input logic [9:0] a, input logic [7:0] d, input int nbits);
    hdr(8'h02, a);
    u_host.tx[3] = d;
    u_host.tx[4] = 8'h88;
    u_host.xfer(nbits);
    settle();
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic t_power();
    repeat (10) @(negedge sys_clk_i);
    `CHK(rst_oe, 1'b1)
    // short wait after hold, inside both limits
    repeat (50) @(negedge sys_clk_i);
    `CHK(rst_oe, 1'b0)
    rd_stat(8'h18);
  endtask
  task automatic t_guard();
    wr1(10'h010, 8'h5A, 32);
    `CHK(seen, 1'b0)
    latch();
    cmd(8'h04, 8);
    wr1(10'h010, 8'h5A, 32);
    `CHK(seen, 1'b0)
    u_host.tx[0] = 8'h06;
    u_host.tx[1] = 8'h02;
    u_host.tx[2] = 8'h00;
    u_host.tx[3] = 8'h10;
    u_host.tx[4] = 8'h5A;
    u_host.xfer(40);
    wr1(10'h010, 8'h5A, 32);
    `CHK(seen, 1'b0)
  endtask
  task automatic t_commit();
    foreach (u_host.rx[k]) if (k < 3) begin
      latch();
      wr1(10'h011, 8'h77, (k == 0) ? 31 : (k == 1) ? 33 : 36);
      `CHK(seen, 1'b0)
    end
    latch();
    hdr(8'h02, 10'h011);
    u_host.xfer(32);
    rd_stat(8'h80);
    settle();
    `CHK(seen, 1'b1)
    rd_stat(8'h00);
    rd_stat(8'h18);
    wr1(10'h011, 8'h77, 32);
    `CHK(seen, 1'b0)
  endtask
  task automatic t_page();
    latch();
    hdr(8'h02, 10'h120);
    for (k = 0; k < 18; k++) u_host.tx[3+k] = 8'h40 + 8'(k);
    u_host.xfer(168);
    settle();
    `CHK(seen, 1'b1)
    hdr(8'h03, 10'h120);
    u_host.xfer(48);
    `CHK({u_host.rx[3], u_host.rx[4], u_host.rx[5]}, 24'h505142)
  endtask
  task automatic cfg(input logic [7:0] v);
    latch();
    u_host.tx[1] = v;
    cmd(8'h01, 16);
    settle();
    `CHK(seen, 1'b1)
    rd_stat(8'h00);
    rd_stat(v);
  endtask
  task automatic t_protect();
    latch();
    wr1(10'h3F5, 8'h11, 32);
    cfg(8'h1F);
    latch();
    wr1(10'h3F5, 8'hA5, 32);
    hdr(8'h03, 10'h3F5);
    u_host.xfer(32);
    `CHK(u_host.rx[3], 8'h11)
  endtask
  task automatic t_wdog();
    cfg(8'h10);
    repeat (100) @(negedge sys_clk_i);
    `CHK(rst_oe, 1'b0)
    for (n = 0; n < 800 && rst_oe !== 1'b1; n++) @(negedge sys_clk_i);
    `CHK(rst_oe, 1'b1)
    cfg(8'h18);
  endtask
  task automatic t_vcc();
    @(posedge sys_clk_i) vcc_low_i <= 1'b1;
    repeat (10) @(negedge sys_clk_i);
    `CHK(rst_oe, 1'b1)
    latch();
    wr1(10'h050, 8'h33, 32);
    `CHK(seen, 1'b0)
    @(posedge sys_clk_i) vcc_low_i <= 1'b0;
    repeat (80) @(negedge sys_clk_i);
    `CHK(rst_oe, 1'b0)
    wr1(10'h050, 8'h33, 32);
    `CHK(seen, 1'b0)
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  // Ceiling well above the longest expected run
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 80000) begin
      fail_count++;
      finish_test();
    end
  end
  initial begin
    resetn_i = 1'b0;
    vcc_low_i = 1'b0;
    repeat (3) @(negedge sys_clk_i);
    `CHK({so_oe, rst_oe, busy}, 3'b010)
    @(posedge sys_clk_i) resetn_i <= 1'b1;
    t_power();
    t_guard();
    t_commit();
    t_page();
    t_protect();
    t_wdog();
    t_vcc();
    finish_test();
  end
endmodule
